/* hdl/input_clock_qualifier.sv */
// Input clock qualifier: lock modes, rate and activity monitors, APB registers
// What this block does
// - Rate select picks 1.544 or 2.048 MHz
// - Rate select default taken from strap pin
// - Two config bits choose the locking mode
// - Direct lock at the configured rate
// - 155.52 MHz halved to 77.76 MHz
// - Alternate rates divided to 31.25 or 5 MHz
// - 8 kHz mode divides reference to 8 kHz
// - 2k and 4k inputs set to 8 kHz mode lock direct
// - Polarity bit picks 8 kHz lock edge
// - Shared divider divides by value plus one
// - Valid bit, latched change flag, interrupt request
// - Invalid inputs never offered for selection
// - Aux PLL no-input flag when none valid
// - Rate check at 1 percent, can disable
// - Four bucket configurations, assigned per input
// - Fill once per 128 ms on inactivity
// - Leak after 1, 2, 4 or 8 quiet intervals
// - Declare threshold sets alarm, invalidates input
// - Clear threshold clears the alarm
// - Bucket saturates at its size
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module input_clock_qualifier
	import qual_pkg::*;
#(
	parameter int INTERVAL_CYC = INTERVAL_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_IN-1:0] ref_clk_in,
	input wire logic sonet_sdh_pin,
	output logic [NUM_IN-1:0] ref_tick,
	output logic [NUM_IN-1:0] ref_valid,
	output logic aux_pll_no_input,
	output logic irq_request
);
	////////////////////////////////////////////////////////////////
	// Declarations
	logic input_frequency_field_monitor_enable_ff; // Rate check on
	logic sonet_sdh_rate_select_ff; // 1 selects the 1.544 MHz rate
	logic strap_load_ff; // Strap not yet taken
	logic strap_s1_ff; // Strap synchroniser, first stage
	logic strap_s2_ff;
	logic eight_khz_edge_polarity_ff; // 1 locks to falling edges
	logic [15:0] shared_divider_value_ff;
	logic [7:0] input_clock_config_ff [NUM_IN];
	logic [25:0] bucket_cfg_ff [4];
	logic [NUM_IN-1:0] valid_ff; // Real-time valid bits
	logic [NUM_IN-1:0] change_ff; // Latched valid changes
	logic [8:0] irq_enable_ff;
	logic [NUM_IN-1:0] aux_mask_ff; // Inputs the aux PLL may use
	logic aux_none_ff; // Real-time aux no-input
	logic aux_latched_ff; // Latched aux no-input
	logic [NUM_IN-1:0] act_alarm; // From the buckets
	logic [NUM_IN-1:0] rate_alarm; // From the rate monitors
	logic [NUM_IN-1:0] nxt_valid;
	logic [22:0] interval_cnt_ff; // Position within the interval
	logic interval_tick; // Last cycle of an interval
	logic [31:0] prdata_ff;
	logic [31:0] nxt_rdata;
	logic addr_hit; // Address maps to a register
	logic wr_en; // Write takes effect this edge
	logic rd_setup; // Read setup phase

	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;
	assign prdata = prdata_ff;
	assign ref_valid = valid_ff;
	assign aux_pll_no_input = aux_none_ff;

	////////////////////////////////////////////////////////////////
	// Strap capture; synchroniser runs through reset
	always_ff @(posedge pclk) begin
		strap_s1_ff <= sonet_sdh_pin;
		strap_s2_ff <= strap_s1_ff;
	end

	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_frequency_field_monitor_enable_ff <= CTRL1_RST;
			sonet_sdh_rate_select_ff <= 1'b0;
			strap_load_ff <= 1'b1;
			eight_khz_edge_polarity_ff <= 1'b0;
			shared_divider_value_ff <= 16'h0000;
			irq_enable_ff <= 9'h000;
			aux_mask_ff <= AUXMASK_RST;
		end else begin
			strap_load_ff <= 1'b0;
			if (strap_load_ff) begin
				sonet_sdh_rate_select_ff <= strap_s2_ff;
			end else if (wr_en && paddr == OFF_CTRL3) begin
				sonet_sdh_rate_select_ff <= pwdata[0];
			end
			if (wr_en) begin
				unique case (paddr)
					OFF_CTRL1: input_frequency_field_monitor_enable_ff <= pwdata[0];
					OFF_TEST_CONTROL_ONE: eight_khz_edge_polarity_ff <= pwdata[0];
					OFF_DIVIDER: shared_divider_value_ff <= pwdata[15:0];
					OFF_IRQEN: irq_enable_ff <= pwdata[8:0];
					OFF_AUXMASK: aux_mask_ff <= pwdata[NUM_IN-1:0];
					default: ;
				endcase
			end
		end
	end

	// Bucket configuration sets, one word each
	// four programmable sets
	for (genvar k = 0; k < 4; k++) begin : g_bkt
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				bucket_cfg_ff[k] <= BKT_RST;
			end else if (wr_en && paddr == OFF_BKT0 + 8'(4 * k)) begin
				bucket_cfg_ff[k] <= pwdata[25:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Interval timer shared by every input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interval_cnt_ff <= 23'h000000;
		end else if (interval_tick) begin
			interval_cnt_ff <= 23'h000000;
		end else begin
			interval_cnt_ff <= interval_cnt_ff + 23'h000001;
		end
	end
	assign interval_tick = (interval_cnt_ff == 23'(INTERVAL_CYC - 1));

	////////////////////////////////////////////////////////////////
	// Per-input monitor and divider
	for (genvar i = 0; i < NUM_IN; i++) begin : g_in
		logic s1_ff; // Pin synchroniser, first stage
		logic s2_ff;
		logic s3_ff; // Edge detect delay
		logic rise;
		logic fall;
		logic [7:0] cfg;
		lock_mode_t mode; // Effective mode
		rate_info_t info;
		logic [15:0] gap_ff; // Cycles since the last rising edge
		logic inact_ff; // Inactivity seen this interval
		logic [24:0] edges_ff; // Rising edges this interval
		logic [47:0] exp_wide;
		logic [24:0] expect_n;
		logic [24:0] dev;
		logic rate_bad;
		logic rate_alarm_ff;
		logic [16:0] divisor;
		logic [16:0] div_cnt_ff;
		logic lock_edge;
		logic tick_ff;
		bucket_if bi();

		assign cfg = input_clock_config_ff[i];
		assign info = rate_info(cfg[CFG_RATE_LSB +: 4], cfg[CFG_DIV_BIT] & cfg[CFG_8K_BIT],
			sonet_sdh_rate_select_ff);

		// Configuration word
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				input_clock_config_ff[i] <= (i < 4) ? CFG_RST_LOW : CFG_RST_HIGH;
			end else if (wr_en && paddr == OFF_CFG0 + 8'(4 * i)) begin
				input_clock_config_ff[i] <= pwdata[7:0];
			end
		end

		// Mode decode
		always_comb begin
			mode = lock_mode_t'({cfg[CFG_DIV_BIT], cfg[CFG_8K_BIT]});
			if (mode == MODE_8K && cfg[CFG_RATE_LSB +: 4] <= 4'h1) begin
				mode = MODE_DIRECT;
			end
		end

		// Divisor per mode
		always_comb begin
			unique case (mode)
				MODE_DIRECT: divisor = {14'h0000, info.pre};
				MODE_8K: divisor = {2'b00, info.khz[17:3]};
				MODE_DIVIDE: divisor = {1'b0, shared_divider_value_ff} + 17'h00001;
				// alternate rates to 31.25 or 5 MHz
				MODE_ALT: divisor = {14'h0000, info.pre};
			endcase
		end

		// Pin synchroniser
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				s1_ff <= 1'b0;
				s2_ff <= 1'b0;
				s3_ff <= 1'b0;
			end else begin
				s1_ff <= ref_clk_in[i];
				s2_ff <= s1_ff;
				s3_ff <= s2_ff;
			end
		end
		assign rise = s2_ff & ~s3_ff;
		assign fall = ~s2_ff & s3_ff;
		// edge choice in 8 kHz mode
		assign lock_edge = (mode == MODE_8K && eight_khz_edge_polarity_ff) ? fall : rise;

		// Reference divider; a tick marks each locking event
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				div_cnt_ff <= 17'h00000;
				tick_ff <= 1'b0;
			end else begin
				tick_ff <= 1'b0;
				if (lock_edge) begin
					if (div_cnt_ff + 17'h00001 >= divisor) begin
						div_cnt_ff <= 17'h00000;
						tick_ff <= 1'b1;
					end else begin
						div_cnt_ff <= div_cnt_ff + 17'h00001;
					end
				end
			end
		end
		assign ref_tick[i] = tick_ff;

		// Inactivity: a gap longer than two periods (fast rates four pclk cycles)
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				gap_ff <= 16'h0000;
				inact_ff <= 1'b0;
			end else begin
				if (rise) begin
					gap_ff <= 16'h0000;
				end else if (gap_ff != 16'hFFFF) begin
					gap_ff <= gap_ff + 16'h0001;
				end
				if (interval_tick) begin
					inact_ff <= 1'b0;
				end else if (gap_ff >= info.gap) begin
					inact_ff <= 1'b1;
				end
			end
		end

		// Rate check over the interval against the pclk reference
		assign exp_wide = (48'(info.khz) * 48'(INTERVAL_CYC)) / 48'(CLK_KHZ);
		assign expect_n = exp_wide[24:0];
		assign dev = (edges_ff > expect_n) ? edges_ff - expect_n : expect_n - edges_ff;
		assign rate_bad = input_frequency_field_monitor_enable_ff && (dev > expect_n / 25'(TOL_DIV));

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				edges_ff <= 25'h0000000;
				rate_alarm_ff <= 1'b0;
			end else begin
				if (interval_tick) begin
					edges_ff <= {24'h000000, rise};
					rate_alarm_ff <= rate_bad;
				end else if (rise) begin
					edges_ff <= edges_ff + 25'h0000001;
				end
				// disabling clears the fault at once
				if (!input_frequency_field_monitor_enable_ff) begin
					rate_alarm_ff <= 1'b0;
				end
			end
		end
		assign rate_alarm[i] = rate_alarm_ff;

		// Bucket hookup
		assign bi.tick = interval_tick;
		assign bi.fill = inact_ff | (gap_ff >= info.gap) | rate_bad;
		assign bi.size = bucket_cfg_ff[cfg[CFG_BKT_LSB +: 2]][BK_SIZE_LSB +: 8];
		assign bi.declare = bucket_cfg_ff[cfg[CFG_BKT_LSB +: 2]][BK_DECL_LSB +: 8];
		assign bi.clear = bucket_cfg_ff[cfg[CFG_BKT_LSB +: 2]][BK_CLR_LSB +: 8];
		assign bi.decay = bucket_cfg_ff[cfg[CFG_BKT_LSB +: 2]][BK_DEC_LSB +: 2];
		assign act_alarm[i] = bi.alarm;

		leaky_bucket u_bucket (
			.pclk(pclk),
			.presetn(presetn),
			.bi(bi)
		);
	end

	////////////////////////////////////////////////////////////////
	// Valid state and change flags
	// alarm invalidates the input
	assign nxt_valid = ~act_alarm & ~rate_alarm;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valid_ff <= {NUM_IN{1'b1}};
			change_ff <= {NUM_IN{1'b0}};
			aux_none_ff <= 1'b0;
			aux_latched_ff <= 1'b0;
		end else begin
			// only valid inputs leave as eligible
			valid_ff <= nxt_valid;
			// change sets flag, set wins over clear
			change_ff <= (change_ff & ~((wr_en && paddr == OFF_CHANGE) ? pwdata[NUM_IN-1:0] : 8'h00))
				| (valid_ff ^ nxt_valid);
			// no usable input for the aux PLL
			aux_none_ff <= ~|(valid_ff & aux_mask_ff);
			if (aux_none_ff) begin
				aux_latched_ff <= 1'b1;
			end else if (wr_en && paddr == OFF_AUXST && pwdata[0]) begin
				aux_latched_ff <= 1'b0;
			end
		end
	end

	// request when flag and enable meet
	assign irq_request = |(change_ff & irq_enable_ff[NUM_IN-1:0])
		| (aux_latched_ff & irq_enable_ff[IRQ_AUX_BIT]);

	////////////////////////////////////////////////////////////////
	// Read decode; data is latched in the setup phase
	always_comb begin
		nxt_rdata = 32'h00000000;
		addr_hit = 1'b1;
		unique case (paddr)
			OFF_CTRL1: nxt_rdata[0] = input_frequency_field_monitor_enable_ff;
			OFF_CTRL3: nxt_rdata[0] = sonet_sdh_rate_select_ff;
			OFF_TEST_CONTROL_ONE: nxt_rdata[0] = eight_khz_edge_polarity_ff;
			OFF_DIVIDER: nxt_rdata[15:0] = shared_divider_value_ff;
			OFF_VALID: nxt_rdata[NUM_IN-1:0] = valid_ff;
			OFF_CHANGE: nxt_rdata[NUM_IN-1:0] = change_ff;
			OFF_IRQEN: nxt_rdata[8:0] = irq_enable_ff;
			OFF_ALARM: nxt_rdata[15:0] = {rate_alarm, act_alarm};
			OFF_AUXST: nxt_rdata[1:0] = {aux_none_ff, aux_latched_ff};
			OFF_AUXMASK: nxt_rdata[NUM_IN-1:0] = aux_mask_ff;
			default: begin
				if (paddr[7:5] == 3'h0 && paddr[4] && paddr[1:0] == 2'h0) begin
					// Input configuration words
					nxt_rdata[7:0] = input_clock_config_ff[paddr[4:2] - 3'h4];
				end else if (paddr[7:4] == 4'h3 && paddr[1:0] == 2'h0) begin
					// Bucket configuration words
					nxt_rdata[25:0] = bucket_cfg_ff[paddr[3:2]];
				end else if (paddr[7:4] == 4'h2 && paddr[1:0] == 2'h0) begin
					nxt_rdata[7:0] = input_clock_config_ff[{1'b1, paddr[3:2]}];
				end else begin
					addr_hit = 1'b0;
				end
			end
		endcase
	end

	// Read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h00000000;
		end else if (rd_setup) begin
			prdata_ff <= nxt_rdata;
		end
	end
endmodule

/* hdl/leaky_bucket.sv */
// Leaky bucket accumulator for one input clock
`timescale 1ns/1ps
module leaky_bucket
	import qual_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	bucket_if.bkt bi
);
	logic [7:0] level_ff; // Current fill level
	logic [3:0] quiet_ff; // Quiet intervals since the last leak or fill
	logic alarm_ff; // Activity alarm
	logic [7:0] nxt_level;
	logic [3:0] nxt_quiet;
	logic nxt_alarm;
	logic [3:0] period; // Leak period in intervals

	assign period = 4'h1 << bi.decay;
	assign bi.alarm = alarm_ff;

	////////////////////////////////////////////////////////////////
	// Fill, leak and alarm hysteresis, evaluated once per interval
	always_comb begin
		nxt_level = level_ff;
		nxt_quiet = quiet_ff;
		nxt_alarm = alarm_ff;
		if (bi.tick) begin
			if (bi.fill) begin
				nxt_quiet = 4'h0;
				if (level_ff < bi.size) begin
					nxt_level = level_ff + 8'h01;
				end
			end else if (quiet_ff + 4'h1 >= period) begin
				nxt_quiet = 4'h0;
				if (level_ff != 8'h00) begin
					nxt_level = level_ff - 8'h01;
				end
			end else begin
				nxt_quiet = quiet_ff + 4'h1;
			end
			if (!alarm_ff && nxt_level >= bi.declare) begin
				nxt_alarm = 1'b1;
			end else if (alarm_ff && nxt_level <= bi.clear) begin
				nxt_alarm = 1'b0;
			end
		end
	end

	// Bucket state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_ff <= 8'h00;
			quiet_ff <= 4'h0;
			alarm_ff <= 1'b0;
		end else begin
			level_ff <= nxt_level;
			quiet_ff <= nxt_quiet;
			alarm_ff <= nxt_alarm;
		end
	end
endmodule

/* pkg/bucket_if.sv */
// Link between an input monitor and its leaky bucket
`timescale 1ns/1ps
interface bucket_if;
	logic tick; // Interval boundary pulse
	logic fill; // Irregularity seen in the closing interval
	logic [7:0] size;
	logic [7:0] declare;
	logic [7:0] clear;
	logic [1:0] decay;
	logic alarm; // Activity alarm
	modport mon(output tick, fill, size, declare, clear, decay, input alarm);
	modport bkt(input tick, fill, size, declare, clear, decay, output alarm);
endinterface

/* pkg/qual_pkg.sv */
// Shared constants, types and rate tables for the input clock qualifier
package qual_pkg;
	localparam int NUM_IN = 8;
	localparam int CLK_KHZ = 40000;
	localparam int INTERVAL_MS = 128;
	localparam int INTERVAL_CYCLES = CLK_KHZ * INTERVAL_MS;
	localparam int TOL_PPM = 10000;
	localparam int TOL_DIV = 1000000 / TOL_PPM;
	localparam int MIN_GAP = 4;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL1 = 8'h00;
	localparam logic [7:0] OFF_CTRL3 = 8'h04;
	localparam logic [7:0] OFF_TEST_CONTROL_ONE = 8'h08;
	localparam logic [7:0] OFF_DIVIDER = 8'h0C;
	localparam logic [7:0] OFF_CFG0 = 8'h10;
	localparam logic [7:0] OFF_BKT0 = 8'h30;
	localparam logic [7:0] OFF_VALID = 8'h40;
	localparam logic [7:0] OFF_CHANGE = 8'h44;
	localparam logic [7:0] OFF_IRQEN = 8'h48;
	localparam logic [7:0] OFF_ALARM = 8'h4C;
	localparam logic [7:0] OFF_AUXST = 8'h50;
	localparam logic [7:0] OFF_AUXMASK = 8'h54;
	// Field positions
	localparam int CFG_RATE_LSB = 0;
	localparam int CFG_8K_BIT = 4;
	localparam int CFG_DIV_BIT = 5;
	localparam int CFG_BKT_LSB = 6;
	localparam int BK_SIZE_LSB = 0;
	localparam int BK_DECL_LSB = 8;
	localparam int BK_CLR_LSB = 16;
	localparam int BK_DEC_LSB = 24;
	localparam int IRQ_AUX_BIT = 8;
	// Reset values
	localparam logic CTRL1_RST = 1'b1;
	localparam logic [7:0] CFG_RST_LOW = 8'h02;
	localparam logic [7:0] CFG_RST_HIGH = 8'h07;
	localparam logic [25:0] BKT_RST = 26'h001080A;
	localparam logic [7:0] AUXMASK_RST = 8'hFF;
	// Locking mode, coded as {divider enable, 8 kHz lock}
	typedef enum logic [1:0] {
		MODE_DIRECT = 2'b00,
		MODE_8K = 2'b01,
		MODE_DIVIDE = 2'b10,
		MODE_ALT = 2'b11
	} lock_mode_t;
	// Nominal rate, pre-divider, inactivity gap in pclk cycles
	typedef struct packed {
		logic [17:0] khz;
		logic [2:0] pre;
		logic [15:0] gap;
	} rate_info_t;
	// Gap figures assume a 40 MHz pclk
	function automatic rate_info_t rate_info(input logic [3:0] code, input logic alt, input logic sonet);
		rate_info_t r;
		r = '{18'h00008, 3'h1, 16'h2711};
		if (alt) begin
			unique case (code)
				4'h1: r = '{18'h061A8, 3'h5, 16'h0008};
				4'h2: r = '{18'h0F424, 3'h2, 16'h0004};
				4'h3: r = '{18'h1E848, 3'h4, 16'h0004};
				4'h4: r = '{18'h2625A, 3'h5, 16'h0004};
				default: r = '{18'h02710, 3'h2, 16'h0011};
			endcase
		end else begin
			unique case (code)
				4'h0: r = '{18'h00002, 3'h1, 16'h9C41};
				4'h1: r = '{18'h00004, 3'h1, 16'h4E21};
				4'h2: r = '{18'h00008, 3'h1, 16'h2711};
				4'h3: r = sonet ? '{18'h00608, 3'h1, 16'h0035} : '{18'h00800, 3'h1, 16'h0028};
				4'h4: r = '{18'h01388, 3'h1, 16'h0011};
				4'h5: r = '{18'h018A8, 3'h1, 16'h000E};
				4'h6: r = '{18'h01950, 3'h1, 16'h000E};
				4'h7: r = '{18'h04BF0, 3'h1, 16'h0006};
				4'h8: r = '{18'h06540, 3'h1, 16'h0005};
				4'h9: r = '{18'h07A12, 3'h1, 16'h0004};
				4'hA: r = '{18'h097E0, 3'h1, 16'h0004};
				4'hB: r = '{18'h0CA80, 3'h1, 16'h0004};
				4'hC: r = '{18'h12FC0, 3'h1, 16'h0004};
				4'hD: r = '{18'h25F80, 3'h2, 16'h0004};
				4'hE: r = '{18'h061A8, 3'h1, 16'h0008};
				4'hF: r = '{18'h0F424, 3'h1, 16'h0004};
			endcase
		end
		return r;
	endfunction
endpackage

/* test/input_clock_qualifier_checker.sv */
// Port-level assertions for the input clock qualifier
`timescale 1ns/1ps
module input_clock_qualifier_checker
	import qual_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NUM_IN-1:0] ref_clk_in,
	input wire logic sonet_sdh_pin,
	input wire logic [NUM_IN-1:0] ref_tick,
	input wire logic [NUM_IN-1:0] ref_valid,
	input wire logic aux_pll_no_input,
	input wire logic irq_request
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// Bus answer
	AST_ACCESS_READY: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	AST_ERR_IN_ACCESS: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	AST_ERR_READ_ZERO: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("refused read returned data");
	AST_READ_HOLD: assert property (psel && !penable && !pwrite ##1 psel && penable |=> $stable(prdata))
		else $error("read data moved in access phase");
	////////////////////////////////////////////////////////////////
	// Lock pulses need two synchronised samples per input edge
	AST_TICK_PULSE: assert property (|ref_tick |=> (ref_tick & $past(ref_tick)) == 8'h00)
		else $error("lock pulse longer than one cycle");
	AST_NO_INPUT: assert property ((ref_valid == 8'h00) [*3] |-> aux_pll_no_input)
		else $error("no-input flag missing with all inputs invalid");
	// Only software clears a flag or an enable
	AST_IRQ_FALL: assert property ($fell(irq_request) |-> $past(psel && penable && pwrite))
		else $error("request dropped without a write");
	AST_IRQ_RISE: assert property ($rose(irq_request) |-> $past(psel && penable && pwrite)
		|| ref_valid != $past(ref_valid) || $past(ref_valid) != $past(ref_valid, 2)
		|| aux_pll_no_input != $past(aux_pll_no_input)
		|| $past(aux_pll_no_input) != $past(aux_pll_no_input, 2))
		else $error("request raised without a cause");
	////////////////////////////////////////////////////////////////
	// Main scenarios reached
	COV_INVALID: cover property ($fell(ref_valid[5]));
	COV_IRQ: cover property ($rose(irq_request));
	COV_REFUSE: cover property (pslverr);
	COV_NOIN: cover property ($rose(aux_pll_no_input));
endmodule
bind input_clock_qualifier input_clock_qualifier_checker i_checker (.pclk(pclk), .presetn(presetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk_in), .sonet_sdh_pin(sonet_sdh_pin),
	.ref_tick(ref_tick), .ref_valid(ref_valid), .aux_pll_no_input(aux_pll_no_input),
	.irq_request(irq_request));

/* test/input_clock_qualifier_tb.sv */
// Self-checking bench for the input clock qualifier
`timescale 1ns/1ps
module input_clock_qualifier_tb
	import qual_pkg::*;
;
	localparam int IV = 4000; // Short interval keeps the run brief
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, err, aux_pll_no_input, irq_request;
	logic [NUM_IN-1:0] ref_clk_in, ref_tick, ref_valid;
	logic [NUM_IN-1:0] run = 8'hFF, fast = 8'h00, prev_clk = 8'h00;
	logic strap = 1'b0; // Rate strap, low for the first reset
	int edges [NUM_IN] = '{default: 0}; // Source edges seen
	int ticks [NUM_IN] = '{default: 0}; // Lock pulses seen
	int num_errors = 0;
	int checks = 0;
	always #12.5 pclk = ~pclk;
	input_clock_qualifier #(.INTERVAL_CYC(IV)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk_in), .sonet_sdh_pin(strap),
		.ref_tick(ref_tick), .ref_valid(ref_valid), .aux_pll_no_input(aux_pll_no_input),
		.irq_request(irq_request));
	ref_clk_model i_src (.run(run), .fast(fast), .clk_out(ref_clk_in));
	// Count source edges and lock pulses for the ratio checks
	always @(posedge pclk) begin
		for (int i = 0; i < NUM_IN; i++) begin
			if (ref_clk_in[i] && !prev_clk[i]) edges[i]++;
			if (ref_tick[i] === 1'b1) ticks[i]++;
		end
		prev_clk <= ref_clk_in;
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One bus transfer; an edge passes after release so calls may follow
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only the watchdog bounds this wait
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_valid(input int i, input logic v, input int lim);
		int n;
		n = 0;
		while (ref_valid[i] !== v && n < lim) begin
			@(posedge pclk);
			n++;
		end
		check("valid state", ref_valid[i], v);
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic test_regs();
		logic [7:0] a [7] = '{OFF_CTRL1, OFF_CTRL3, OFF_CFG0, OFF_CFG0 + 8'h1C, OFF_BKT0, OFF_VALID, OFF_AUXMASK};
		logic [31:0] e [7] = '{32'h1, 32'h1, 32'h2, 32'h7, {6'h0, BKT_RST}, 32'hFF, 32'hFF};
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, a[i], 32'h0);
			check("reset value", q, e[i]);
		end
		// Status is read-only, the write must be dropped
		apb(1'b1, OFF_VALID, 32'h0);
		apb(1'b0, OFF_VALID, 32'h0);
		check("read-only valid", q, 32'hFF);
		apb(1'b0, 8'hFC, 32'h0);
		check("unmapped error", {31'h0, err}, 32'h1);
		check("unmapped data", q, 32'h0);
		$display("test regs done");
	endtask
	task automatic setup_inputs();
		// size 3, declare 2, clear 1, leak every interval
		apb(1'b1, OFF_BKT0, 32'h00010203);
		for (int i = 0; i < NUM_IN; i++) apb(1'b1, OFF_CFG0 + 8'(4 * i), 32'h04);
		repeat (2 * IV) @(posedge pclk);
	endtask
	task automatic test_modes();
		logic [31:0] cfg [6] = '{32'h04, 32'h24, 32'h31, 32'h0D, 32'h10, 32'h12};
		int dv [6] = '{1, 4, 5, 2, 1, 1};
		int e0 [6];
		int t0 [6];
		int d;
		apb(1'b1, OFF_DIVIDER, 32'h3);
		// 8 kHz mode on input 5 locks to falling edges
		apb(1'b1, OFF_TEST_CONTROL_ONE, 32'h1);
		for (int i = 0; i < 6; i++) apb(1'b1, OFF_CFG0 + 8'(4 * i), cfg[i]);
		repeat (8) @(posedge pclk);
		for (int i = 0; i < 6; i++) begin
			e0[i] = edges[i];
			t0[i] = ticks[i];
		end
		repeat (2000) @(posedge pclk);
		for (int i = 0; i < 6; i++) begin
			d = (edges[i] - e0[i]) / dv[i] - (ticks[i] - t0[i]);
			check("lock pulse ratio", {31'h0, d >= -1 && d <= 1}, 32'h1);
			apb(1'b1, OFF_CFG0 + 8'(4 * i), 32'h04);
		end
		$display("test modes done");
	endtask
	task automatic test_activity();
		apb(1'b1, OFF_IRQEN, 32'h0);
		apb(1'b1, OFF_CHANGE, 32'hFF);
		run <= 8'h00;
		// The rate fault invalidates first; the next interval's fill declares
		wait_valid(5, 1'b0, 3 * IV);
		for (int n = 0; n < 50 && ref_valid !== 8'h00; n++) @(posedge pclk);
		repeat (IV + 8) @(posedge pclk);
		check("no input", aux_pll_no_input, 1'b1);
		apb(1'b0, OFF_ALARM, 32'h0);
		check("activity alarm", q[5], 1'b1);
		apb(1'b0, OFF_CHANGE, 32'h0);
		check("change flag", q[5], 1'b1);
		check("masked request", irq_request, 1'b0);
		apb(1'b1, OFF_IRQEN, 32'h20);
		check("enabled request", irq_request, 1'b1);
		apb(1'b1, OFF_CHANGE, 32'h20);
		check("cleared request", irq_request, 1'b0);
		// Long outage: only saturation keeps recovery short
		repeat (3 * IV) @(posedge pclk);
		run <= 8'hFF;
		wait_valid(5, 1'b1, 3 * IV + IV / 2);
		apb(1'b0, OFF_ALARM, 32'h0);
		check("alarm cleared", q[5], 1'b0);
		apb(1'b1, OFF_IRQEN, 32'h0);
		$display("test activity done");
	endtask
	task automatic test_rate();
		// Let the level left by the recovery leak away first
		repeat (IV) @(posedge pclk);
		fast <= 8'h40;
		wait_valid(6, 1'b0, 3 * IV);
		apb(1'b0, OFF_ALARM, 32'h0);
		check("rate alarm only", q & 32'h4040, 32'h4000);
		apb(1'b1, OFF_CTRL1, 32'h0);
		apb(1'b0, OFF_ALARM, 32'h0);
		check("rate check off", q[14], 1'b0);
		wait_valid(6, 1'b1, 3 * IV);
		fast <= 8'h00;
		apb(1'b1, OFF_CTRL1, 32'h1);
		$display("test rate done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFF_CTRL3, 32'h0);
		check("strap low", q, 32'h0);
		// Second reset with the strap high
		strap <= 1'b1;
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		test_regs();
		setup_inputs();
		test_modes();
		test_activity();
		test_rate();
		give_verdict();
	end
	// Hang guard, well past the planned run length
	initial begin
		repeat (100000) @(posedge pclk);
		num_errors++;
		give_verdict();
	end
endmodule

/* test/ref_clk_model.sv */
// Behavioural reference clock sources that stand in for the line cards
`timescale 1ns/1ps
module ref_clk_model
	import qual_pkg::*;
(
	input wire logic [NUM_IN-1:0] run,
	input wire logic [NUM_IN-1:0] fast,
	output logic [NUM_IN-1:0] clk_out
);
	////////////////////////////////////////////////////////////////
	// One free source per input, phases staggered against pclk
	for (genvar i = 0; i < NUM_IN; i++) begin : g_src
		logic c; // Source level
		assign clk_out[i] = c;
		// standard 5 MHz rate, 4 percent high when fast
		initial begin
			c = 1'b0;
			#(3 + 7 * i);
			forever begin
				// A stopped source holds low, like a dead card
				if (run[i]) begin
					c = ~c;
				end else begin
					c = 1'b0;
				end
				#(fast[i] ? 96 : 100);
			end
		end
	end
endmodule
